// ---- design/sl_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the link controller.
`ifndef SL_DEFS_SVH
`define SL_DEFS_SVH

`define SL_OFS_CON1    6'h00
`define SL_OFS_CON2    6'h04
`define SL_OFS_CON3    6'h08
`define SL_OFS_STAT    6'h0c
`define SL_OFS_DATH    6'h10
`define SL_OFS_DATL    6'h14

`define SL_CON1_MASK   16'hafd7
`define SL_RST16       16'h0000
`define SL_RST32       32'h0000_0000

`define SL_B_ON        15
`define SL_B_SIDL      13
`define SL_B_RX        11
`define SL_B_TXM       10
`define SL_B_POL       9
`define SL_B_CRC       8
`define SL_B_PPP       7
`define SL_B_SPC       6
`define SL_B_PS        4
`define SL_F_NIB       2:0

`define SL_S_CRCERR    3
`define SL_S_FRMERR    2
`define SL_S_GO        0

`define SL_NIB_RES_LO  3'h0
`define SL_NIB_RES_HI  3'h7
`define SL_NIB_MIN     3'h1
`define SL_NIB_MAXN    3'h6
`define SL_NIB_CRCIDX  3'h7

`define SL_SYNC_TICKS  12'd56
`define SL_NIB_OFS     12'd12
`define SL_NIB_MAX     12'd27
// Sync limits count in units of seven module clocks, so a 56-tick sync is eight counts per module clock of tick length.
`define SL_SYNC_SCALE  19'd7
`define SL_LOW_TICKS   12'd5
`define SL_PAUSE_MIN   12'd12
`define SL_FRAME_MAX   12'd2047

`define SL_PS_LAST     2'h3
`define SL_CRC_SEED    4'h5
`define SL_CRC_POLY    4'hd

`endif

// ---- design/sl_pkg.sv ----
// Types shared by the link controller: frame state and the packed state record.
`default_nettype none
package sl_pkg;

  typedef enum logic [1:0] {
    SL_IDLE  = 2'h0,
    SL_SYNC  = 2'h1,
    SL_NIB   = 2'h3,
    SL_PAUSE = 2'h2
  } sl_state_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [15:0] con1;
    logic [15:0] con2;
    logic [15:0] con3;
    logic [31:0] dat;
    logic [31:0] shadow;
    logic        frm_err;
    logic        crc_err;
    logic        rx_idle;
    logic        go;
    logic        pause;
    logic        done;
    logic        line;
    logic        lvl;
    logic [2:0]  k;
    logic [2:0]  s;
    logic [1:0]  psc;
    sl_state_t   fsm;
    logic [15:0] sec;
    logic [15:0] per;
    logic [15:0] tick_len;
    logic [11:0] tcnt;
    logic [11:0] frm;
  } sl_regs_t;

endpackage
`default_nettype wire

// ---- design/sl_crc.sv ----
// Four-bit frame checksum over the data nibbles, seeded and augmented by one zero nibble.
`include "sl_defs.svh"
`default_nettype none
module sl_crc #(
  parameter int NIBS = 6
) (
  input  wire logic [4*NIBS-1:0] data,
  input  wire logic [2:0]        count,
  output logic      [3:0]        crc
);

  always_comb begin
    logic [3:0] r;
    logic [3:0] n;
    logic       fb;
    r  = `SL_CRC_SEED;
    n  = 4'h0;
    fb = 1'b0;
    for (int i = 0; i < NIBS; i++) begin
      if (i < int'(count)) begin
        n = data[4*(NIBS-1-i) +: 4];
        for (int b = 3; b >= 0; b--) begin
          fb = r[3];
          r  = {r[2:0], n[b]};
          if (fb) r = r ^ `SL_CRC_POLY;
        end
      end
    end
    // The trailing zero nibble pushes the remainder fully through the polynomial.
    for (int b = 3; b >= 0; b--) begin
      fb = r[3];
      r  = {r[2:0], 1'b0};
      if (fb) r = r ^ `SL_CRC_POLY;
    end
    crc = r;
  end

endmodule // sl_crc
`default_nettype wire

// ---- design/sl_ctrl.sv ----
// Single-wire falling-edge nibble link controller with a classic Wishbone register slave.
`include "sl_defs.svh"
`default_nettype none
module sl_ctrl (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [5:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        SENT_RX,
  input  wire logic        IDLE_MODE,
  input  wire logic        SPC_REQ,
  output logic             SENT_TX,
  output logic             FRAME_DONE
);

  sl_pkg::sl_regs_t st;
  sl_pkg::sl_regs_t nx;

  logic        on;
  logic        run;
  logic        rx;
  logic        tx_trigger_select;
  logic        pol;
  logic        mod_en;
  logic        tick;
  logic        new_lvl;
  logic        fall;
  logic        sync_ok;
  logic        bad_nib;
  logic        last_nib;
  logic        wr;
  logic [2:0]  nmax;
  logic [2:0]  slot;
  logic [3:0]  tx_crc;
  logic [3:0]  rx_crc;
  logic [3:0]  cur_nib;
  logic [11:0] sec_len;
  logic [11:0] pause_len;
  logic [11:0] fp;
  logic [11:0] rx_ticks;
  logic [11:0] rx_sub;
  logic [11:0] tcnt_inc;
  logic [15:0] tick_lim;
  logic [15:0] sync_q;
  logic [31:0] tx_word;
  logic [31:0] rd;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [3:0] nib_at(input logic [31:0] w, input logic [2:0] p);
    nib_at = w[{p, 2'b00} +: 4];
  endfunction

  assign on  = st.con1[`SL_B_ON];
  assign run = on & ~(st.con1[`SL_B_SIDL] & IDLE_MODE);
  assign rx  = st.con1[`SL_B_RX];
  assign tx_trigger_select = st.con1[`SL_B_TXM];
  assign pol = st.con1[`SL_B_POL];

  // The divider runs freely so that the enable cadence never depends on bus traffic.
  assign mod_en = ~st.con1[`SL_B_PS] | (st.psc == `SL_PS_LAST);

  // Reserved nibble codes are clamped so a stray write cannot stall the frame engine.
  assign nmax = (st.con1[`SL_F_NIB] == `SL_NIB_RES_LO) ? `SL_NIB_MIN :
                (st.con1[`SL_F_NIB] == `SL_NIB_RES_HI) ? `SL_NIB_MAXN :
                st.con1[`SL_F_NIB];
  assign last_nib = ({1'b0, st.k} == ({1'b0, nmax} + 4'h1));
  assign slot     = ({1'b0, st.k} > {1'b0, nmax}) ? 3'h0 : (3'h7 - st.k);
  assign cur_nib  = nib_at(st.shadow, slot);

  sl_crc #(.NIBS(6)) u_tx_crc (
    .data  (st.dat[27:4]),
    .count (nmax),
    .crc   (tx_crc)
  );

  sl_crc #(.NIBS(6)) u_rx_crc (
    .data  (st.shadow[27:4]),
    .count (nmax),
    .crc   (rx_crc)
  );

  assign tx_word  = {st.dat[31:4], st.con1[`SL_B_CRC] ? tx_crc : st.dat[3:0]};
  assign tick_lim = rx ? (st.tick_len - 16'h0001) : st.con2;
  assign tick     = mod_en & (st.sec >= tick_lim);
  assign tcnt_inc = st.tcnt + 12'h001;

  assign fp        = (st.con3 > {4'h0, `SL_FRAME_MAX}) ? `SL_FRAME_MAX : st.con3[11:0];
  assign pause_len = (fp > (st.frm + `SL_PAUSE_MIN)) ? (fp - st.frm) : `SL_PAUSE_MIN;
  assign sec_len   = (st.fsm == sl_pkg::SL_SYNC) ? `SL_SYNC_TICKS :
                     (st.fsm == sl_pkg::SL_NIB) ? (`SL_NIB_OFS + {8'h00, cur_nib}) :
                     pause_len;

  // Only the second and third stages are compared; the first stage feeds nothing else.
  assign new_lvl  = (st.s[1] == st.s[2]) ? st.s[1] : st.lvl;
  assign fall     = mod_en & st.lvl & ~new_lvl;
  assign sync_ok  = ({3'h0, st.per} >= ({3'h0, st.con3} * `SL_SYNC_SCALE)) &&
                    ({3'h0, st.per} <= ({3'h0, st.con2} * `SL_SYNC_SCALE));
  assign sync_q   = st.per / {4'h0, `SL_SYNC_TICKS};
  assign rx_ticks = st.tcnt + ((st.sec >= (st.tick_len >> 1)) ? 12'h001 : 12'h000);
  assign rx_sub   = rx_ticks - `SL_NIB_OFS;
  assign bad_nib  = (rx_ticks < `SL_NIB_OFS) || (rx_ticks > `SL_NIB_MAX);

  assign wr = CYC_I & STB_I & WE_I & st.ack;

  always_comb begin
    rd = `SL_RST32;
    if (ADR_I == `SL_OFS_CON1) begin
      rd = {16'h0000, st.con1};
    end else if (ADR_I == `SL_OFS_CON2) begin
      rd = {16'h0000, st.con2};
    end else if (ADR_I == `SL_OFS_CON3) begin
      rd = {16'h0000, st.con3};
    end else if (ADR_I == `SL_OFS_STAT) begin
      rd = {24'h000000, st.pause, last_nib ? `SL_NIB_CRCIDX : st.k,
            st.crc_err, st.frm_err, st.rx_idle, (!rx && !tx_trigger_select) ? on : st.go};
    end else if (ADR_I == `SL_OFS_DATH) begin
      rd = {16'h0000, st.dat[31:16]};
    end else if (ADR_I == `SL_OFS_DATL) begin
      rd = {16'h0000, st.dat[15:0]};
    end
  end

  always_comb begin
    nx      = st;
    nx.ack  = CYC_I & STB_I & ~st.ack;
    nx.done = 1'b0;
    nx.psc  = st.psc + 2'h1;
    nx.s    = {st.s[1:0], SENT_RX};
    if (CYC_I && STB_I && !st.ack) nx.rdat = rd;

    if (wr) begin
      if (ADR_I == `SL_OFS_CON1) begin
        nx.con1 = merge16(st.con1, DAT_I, SEL_I) & `SL_CON1_MASK;
      end else if (ADR_I == `SL_OFS_CON2) begin
        nx.con2 = merge16(st.con2, DAT_I, SEL_I);
      end else if (ADR_I == `SL_OFS_CON3) begin
        nx.con3 = merge16(st.con3, DAT_I, SEL_I);
      end else if (ADR_I == `SL_OFS_STAT && SEL_I[0]) begin
        if (!DAT_I[`SL_S_CRCERR]) nx.crc_err = 1'b0;
        if (!DAT_I[`SL_S_FRMERR]) nx.frm_err = 1'b0;
      end else if (ADR_I == `SL_OFS_DATH && !rx) begin
        nx.dat[31:16] = merge16(st.dat[31:16], DAT_I, SEL_I);
      end else if (ADR_I == `SL_OFS_DATL && !rx) begin
        nx.dat[15:0] = merge16(st.dat[15:0], DAT_I, SEL_I);
        if (st.con1[`SL_B_CRC]) nx.dat[3:0] = st.dat[3:0];
      end
    end

    if (!run) begin
      nx.fsm     = sl_pkg::SL_IDLE;
      nx.sec     = `SL_RST16;
      nx.tcnt    = 12'h000;
      nx.k       = 3'h0;
      nx.pause   = 1'b0;
      nx.go      = 1'b0;
      nx.rx_idle = 1'b0;
      nx.line    = rx | ~pol;
    end else if (rx) begin
      if (mod_en) begin
        nx.lvl     = new_lvl;
        nx.per     = fall ? 16'h0001 : ((st.per == 16'hffff) ? st.per : st.per + 16'h0001);
        nx.rx_idle = new_lvl & ({3'h0, st.per} >= ({3'h0, st.con2} * `SL_SYNC_SCALE));
        if (tick) begin
          nx.sec  = `SL_RST16;
          nx.tcnt = (st.tcnt == 12'hfff) ? st.tcnt : tcnt_inc;
        end else begin
          nx.sec = st.sec + 16'h0001;
        end
      end
      case (st.fsm)
        sl_pkg::SL_NIB: begin
          if (fall) begin
            nx.sec  = `SL_RST16;
            nx.tcnt = 12'h000;
            if (bad_nib) begin
              nx.frm_err = 1'b1;
              nx.fsm     = sl_pkg::SL_IDLE;
              nx.go      = 1'b0;
            end else if (last_nib) begin
              nx.dat  = {st.shadow[31:4], rx_sub[3:0]};
              nx.done = 1'b1;
              if (st.con1[`SL_B_CRC] && rx_sub[3:0] != rx_crc) nx.crc_err = 1'b1;
              nx.fsm   = st.con1[`SL_B_PPP] ? sl_pkg::SL_PAUSE : sl_pkg::SL_IDLE;
              nx.pause = st.con1[`SL_B_PPP];
              nx.go    = 1'b0;
              nx.k     = 3'h0;
            end else begin
              nx.shadow[{slot, 2'b00} +: 4] = rx_sub[3:0];
              nx.k = st.k + 3'h1;
            end
          end
        end
        sl_pkg::SL_PAUSE: begin
          if (fall) begin
            nx.fsm   = sl_pkg::SL_IDLE;
            nx.pause = 1'b0;
          end
        end
        default: begin
          if (fall && sync_ok) begin
            nx.tick_len = (sync_q == 16'h0000) ? 16'h0001 : sync_q;
            nx.fsm      = sl_pkg::SL_NIB;
            nx.k        = 3'h0;
            nx.sec      = `SL_RST16;
            nx.tcnt     = 12'h000;
            nx.go       = 1'b1;
          end
        end
      endcase
      // Polarity and trigger mode are ignored here; only short PWM code drives the wire.
      nx.line = ~(st.con1[`SL_B_SPC] & SPC_REQ);
    end else begin
      if (st.fsm == sl_pkg::SL_IDLE) begin
        if (mod_en && (!tx_trigger_select || st.go)) begin
          nx.shadow = tx_word;
          nx.fsm    = sl_pkg::SL_SYNC;
          nx.sec    = `SL_RST16;
          nx.tcnt   = 12'h000;
          nx.frm    = 12'h000;
          nx.k      = 3'h0;
        end
      end else if (mod_en) begin
        if (!tick) begin
          nx.sec = st.sec + 16'h0001;
        end else begin
          nx.sec  = `SL_RST16;
          nx.tcnt = tcnt_inc;
          if (st.fsm != sl_pkg::SL_PAUSE) nx.frm = st.frm + 12'h001;
          if (tcnt_inc == sec_len) begin
            nx.tcnt = 12'h000;
            if (st.fsm == sl_pkg::SL_SYNC) begin
              nx.fsm = sl_pkg::SL_NIB;
            end else if (st.fsm == sl_pkg::SL_NIB && !last_nib) begin
              nx.k = st.k + 3'h1;
            end else if (st.fsm == sl_pkg::SL_NIB && st.con1[`SL_B_PPP]) begin
              nx.fsm   = sl_pkg::SL_PAUSE;
              nx.pause = 1'b1;
            end else begin
              nx.done  = 1'b1;
              nx.k     = 3'h0;
              nx.pause = 1'b0;
              nx.frm   = 12'h000;
              if (!tx_trigger_select) begin
                nx.shadow = tx_word;
                nx.fsm    = sl_pkg::SL_SYNC;
              end else begin
                nx.fsm = sl_pkg::SL_IDLE;
                nx.go  = 1'b0;
              end
            end
          end
        end
      end
      // Each interval opens with a short active phase; the rest is the idle level.
      nx.line = (nx.fsm == sl_pkg::SL_IDLE) ? ~pol : ((nx.tcnt >= `SL_LOW_TICKS) ^ pol);
      // A trigger that lands in the cycle the frame ends is kept and starts the next one.
      if (wr && ADR_I == `SL_OFS_STAT && SEL_I[0] && DAT_I[`SL_S_GO] && tx_trigger_select) nx.go = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st      <= '0;
      st.line <= 1'b1;
      st.lvl  <= 1'b1;
      st.s    <= 3'h7;
    end else begin
      st <= nx;
    end
  end

  assign DAT_O      = st.rdat;
  assign ACK_O      = st.ack;
  assign SENT_TX    = st.line;
  assign FRAME_DONE = st.done;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_rx_last_fall;
    run && rx && st.fsm == sl_pkg::SL_NIB && fall && !bad_nib && last_nib;
  endsequence

  sequence s_sync_end;
    !rx && run && st.fsm == sl_pkg::SL_SYNC && tick && tcnt_inc == `SL_SYNC_TICKS;
  endsequence

  property p_off_idle;
    !on |=> st.fsm == sl_pkg::SL_IDLE && !FRAME_DONE;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("module off but frame engine busy");

  property p_halt;
    on && st.con1[`SL_B_SIDL] && IDLE_MODE |=> st.fsm == sl_pkg::SL_IDLE;
  endproperty
  a_halt: assert property (p_halt) else $error("module not halted in idle");

  property p_rx_line;
    rx && !(st.con1[`SL_B_SPC] && SPC_REQ) |=> SENT_TX;
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("receiver drove the wire");

  property p_trig;
    run && !rx && tx_trigger_select && st.fsm == sl_pkg::SL_IDLE && !st.go && !wr |=>
      st.fsm == sl_pkg::SL_IDLE;
  endproperty
  a_trig: assert property (p_trig) else $error("frame sent without trigger");

  property p_idle_pol;
    run && !rx && nx.fsm == sl_pkg::SL_IDLE |=> SENT_TX == !$past(pol);
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("idle level wrong");

  property p_crc_rx;
    $rose(st.crc_err) |-> $past(st.con1[`SL_B_CRC]) && $past(rx) && FRAME_DONE;
  endproperty
  a_crc_rx: assert property (p_crc_rx) else $error("crc error without check");

  property p_div;
    st.con1[`SL_B_PS] && mod_en |=> (!mod_en || !st.con1[`SL_B_PS])[*3];
  endproperty
  a_div: assert property (p_div) else $error("divide by four cadence wrong");

  property p_sync_len;
    s_sync_end |=> st.fsm == sl_pkg::SL_NIB && st.k == 3'h0 && st.tcnt == 12'h000;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync section length wrong");

  property p_sync_win;
    run && rx && st.fsm == sl_pkg::SL_IDLE && fall && !sync_ok |=> st.fsm != sl_pkg::SL_NIB;
  endproperty
  a_sync_win: assert property (p_sync_win) else $error("sync outside limits taken");

  property p_frm;
    run && rx && st.fsm == sl_pkg::SL_NIB && fall && bad_nib |=>
      st.frm_err && st.fsm == sl_pkg::SL_IDLE;
  endproperty
  a_frm: assert property (p_frm) else $error("framing error missed");

  property p_done;
    s_rx_last_fall |=> FRAME_DONE ##1 !FRAME_DONE;
  endproperty
  a_done: assert property (p_done) else $error("frame completion pulse missing");

endmodule // sl_ctrl
`default_nettype wire

// ---- tb/sl_sensor.sv ----
// Behavioural far-side sensor that drives falling-edge nibble frames onto the receive wire.
`default_nettype none
module sl_sensor (
  input  wire logic clk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;

  // The wire has a pull-up, so it rests high whenever no pulse is driven.
  initial line = 1'b1;

  // One interval: a short low phase then high until the next fall.
  task automatic pulse(input int tick, input int len);
    line <= 1'b0;
    repeat (5 * tick) @(posedge clk);
    line <= 1'b1;
    repeat ((len - 5) * tick) @(posedge clk);
  endtask

  // A long quiet gap first keeps the gap itself from ever looking like a sync interval.
  task automatic send(input int tick, input int lens[$]);
    repeat (400) @(posedge clk);
    foreach (lens[i]) pulse(tick, lens[i]);
    line <= 1'b0;
    repeat (5 * tick) @(posedge clk);
    line <= 1'b1;
  endtask
endmodule // sl_sensor
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the link controller: register bus, transmit and receive frames.
`include "sl_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        MCLK, SYS_RST, CYC_I, STB_I, WE_I, IDLE_MODE, SPC_REQ;
  logic [5:0]  ADR_I;
  logic [3:0]  SEL_I;
  logic [31:0] DAT_I, DAT_O;
  logic        ACK_O, SENT_TX, FRAME_DONE, SENT_RX;
  int          errors = 0, checks = 0, cyc = 0, done_cnt = 0;
  int          edges[$];
  logic        prev = 1'b1, idle_lvl = 1'b1;

  sl_ctrl dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SENT_RX(SENT_RX), .IDLE_MODE(IDLE_MODE), .SPC_REQ(SPC_REQ), .SENT_TX(SENT_TX),
    .FRAME_DONE(FRAME_DONE));
  sl_sensor sensor_u (.clk(MCLK), .line(SENT_RX));

  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  // Leading edges leave the idle level, so they mark the start of every interval.
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    prev <= SENT_TX;
    if (prev === idle_lvl && SENT_TX === !idle_lvl) edges.push_back(cyc);
    if (FRAME_DONE === 1'b1) done_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge MCLK);
    CYC_I <= 1'b1; STB_I <= 1'b1; WE_I <= we; ADR_I <= a; DAT_I <= d; SEL_I <= 4'hf;
    do begin
      @(posedge MCLK);
      n++;
    end while (ACK_O !== 1'b1 && n < 50);
    q = DAT_O;
    CYC_I <= 1'b0; STB_I <= 1'b0; WE_I <= 1'b0;
    if (n >= 50) check(1'b0, 1'b1, "bus answer missing");
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Reference checksum: seed 5, divisor x^4+x^3+x^2+1, one zero nibble appended.
  function automatic logic [3:0] crc4(input logic [23:0] d, input int n);
    logic [3:0] c;
    logic       fb;
    c = 4'h5;
    for (int i = 0; i <= n; i++)
      for (int b = 3; b >= 0; b--) begin
        fb = c[3];
        c = {c[2:0], (i < n) ? d[4 * (n - 1 - i) + b] : 1'b0};
        if (fb) c = c ^ 4'hd;
      end
    return c;
  endfunction

  task automatic expect_frame(input int t, input int lens[$]);
    int n;
    n = 0;
    while (edges.size() < lens.size() + 1 && n < 8000) begin
      @(posedge MCLK);
      n++;
    end
    check(edges.size() >= lens.size() + 1, 1'b1, "too few edges");
    foreach (lens[i])
      if (edges.size() > i + 1)
        check(32'(edges[i + 1] - edges[i]), 32'(lens[i] * t), "interval length");
  endtask

  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, `SL_OFS_CON1, 32'h0, q);
    check(q, 32'h0, "control reset value");
    wb(1'b0, `SL_OFS_STAT, 32'h0, q);
    check(q, 32'h0, "status reset value");
    wr(`SL_OFS_CON1, 32'h0000_7fff);
    wb(1'b0, `SL_OFS_CON1, 32'h0, q);
    check(q, 32'h0000_2fd7, "control readback");
    wb(1'b0, 6'h18, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    wr(`SL_OFS_CON1, 32'h0);
  endtask

  task automatic t_tx;
    int n;
    int d0;
    wr(`SL_OFS_CON2, 32'h1);
    wr(`SL_OFS_DATH, 32'h3a00);
    wr(`SL_OFS_DATL, 32'h0);
    check(SENT_TX, 1'b1, "idle high");
    edges.delete();
    d0 = done_cnt;
    wr(`SL_OFS_CON1, 32'h8101);
    expect_frame(2, '{56, 15, 22, 12 + crc4(24'ha, 1)});
    check(done_cnt > d0, 1'b1, "frame done pulse");
    wr(`SL_OFS_CON1, 32'h0);
    repeat (10) @(posedge MCLK);
    n = edges.size();
    repeat (400) @(posedge MCLK);
    check(edges.size() == n && SENT_TX === 1'b1, 1'b1, "still sending when off");
  endtask

  // The pause stretches every frame to exactly frame_period ticks (at most 2047) when that leaves a pause of at least 12 ticks.
  task automatic t_pause;
    wr(`SL_OFS_CON3, 32'd860);
    edges.delete();
    wr(`SL_OFS_CON1, 32'h8181);
    expect_frame(2, '{56, 15, 22, 12 + crc4(24'ha, 1), 755 - crc4(24'ha, 1)});
    wr(`SL_OFS_CON1, 32'h0);
  endtask

  task automatic t_trig;
    int d0;
    idle_lvl = 1'b0;
    wr(`SL_OFS_DATL, 32'h0007);
    edges.delete();
    wr(`SL_OFS_CON1, 32'h8601);
    repeat (300) @(posedge MCLK);
    check(SENT_TX, 1'b0, "idle low");
    check(edges.size(), 32'h0, "sent without trigger");
    d0 = done_cnt;
    wr(`SL_OFS_STAT, 32'h1);
    expect_frame(2, '{56, 15, 22});
    repeat (400) @(posedge MCLK);
    check(edges.size(), 32'h4, "more than one triggered frame");
    check(done_cnt - d0, 32'h1, "triggered frame done");
    wr(`SL_OFS_CON1, 32'h0);
    idle_lvl = 1'b1;
  endtask

  task automatic t_idle;
    IDLE_MODE <= 1'b1;
    SPC_REQ <= 1'b1;
    wr(`SL_OFS_CON2, 32'h0);
    edges.delete();
    wr(`SL_OFS_CON1, 32'ha111);
    repeat (300) @(posedge MCLK);
    check(edges.size(), 32'h0, "ran during idle");
    IDLE_MODE <= 1'b0;
    expect_frame(4, '{56, 15});
    wr(`SL_OFS_CON1, 32'h0);
    IDLE_MODE <= 1'b1;
    repeat (10) @(posedge MCLK);
    edges.delete();
    wr(`SL_OFS_CON1, 32'h8111);
    expect_frame(4, '{56});
    wr(`SL_OFS_CON1, 32'h0);
    IDLE_MODE <= 1'b0;
    SPC_REQ <= 1'b0;
  endtask

  task automatic rx_frame(input int tick, input int lens[$], output int got);
    int d0;
    d0 = done_cnt;
    sensor_u.send(tick, lens);
    repeat (20) @(posedge MCLK);
    got = done_cnt - d0;
  endtask

  task automatic t_rx;
    logic [31:0] q;
    logic [3:0]  c;
    int          got;
    c = crc4(24'h123, 3);
    wr(`SL_OFS_CON2, 32'd38);
    wr(`SL_OFS_CON3, 32'd25);
    wr(`SL_OFS_CON1, 32'h8b03);
    repeat (10) @(posedge MCLK);
    check(SENT_TX, 1'b1, "polarity used in receive");
    rx_frame(4, '{56, 17, 13, 14, 15, 12 + c}, got);
    check(got, 32'h1, "good frame done");
    wb(1'b0, `SL_OFS_DATH, 32'h0, q);
    check(q, 32'h5123, "received high word");
    wb(1'b0, `SL_OFS_DATL, 32'h0, q);
    check(q[3:0], c, "received checksum");
    wb(1'b0, `SL_OFS_STAT, 32'h0, q);
    check(q[3:2], 2'h0, "errors on good frame");
    rx_frame(4, '{56, 17, 13, 14, 15, 12 + (c ^ 4'h1)}, got);
    wb(1'b0, `SL_OFS_STAT, 32'h0, q);
    check(q[3], 1'b1, "checksum error missed");
    wr(`SL_OFS_STAT, 32'h0);
    rx_frame(4, '{56, 17, 30, 14, 15, 12 + c}, got);
    check(got, 32'h0, "done on bad nibble");
    wb(1'b0, `SL_OFS_STAT, 32'h0, q);
    check(q[2], 1'b1, "framing error missed");
    wr(`SL_OFS_STAT, 32'h0);
    rx_frame(6, '{56, 17, 13, 14, 15, 12 + c}, got);
    check(got, 32'h0, "sync beyond upper limit taken");
    rx_frame(3, '{56, 17, 13, 14, 15, 12 + c}, got);
    check(got, 32'h0, "sync below lower limit taken");
    wr(`SL_OFS_CON1, 32'h8a03);
    rx_frame(4, '{56, 17, 13, 14, 15, 12 + (c ^ 4'h1)}, got);
    wb(1'b0, `SL_OFS_STAT, 32'h0, q);
    check({got == 1, q[3]}, 2'h2, "checksum checked while off");
    wr(`SL_OFS_CON1, 32'h8a43);
    SPC_REQ <= 1'b1;
    repeat (8) @(posedge MCLK);
    check(SENT_TX, 1'b0, "short code request ignored");
    SPC_REQ <= 1'b0;
    repeat (8) @(posedge MCLK);
    check(SENT_TX, 1'b1, "short code line stuck");
  endtask

  initial begin
    SYS_RST = 1'b1; CYC_I = 1'b0; STB_I = 1'b0; WE_I = 1'b0; ADR_I = 6'h00;
    SEL_I = 4'h0; DAT_I = 32'h0; IDLE_MODE = 1'b0; SPC_REQ = 1'b0;
    repeat (6) @(posedge MCLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_tx();
    t_pause();
    t_trig();
    t_idle();
    t_rx();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge MCLK);
    errors++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
